// [core/pbc_defs.svh]
// offsets, field positions, reset values and timing counts for the
// basic phy control register; included by the core
`ifndef PBC_DEFS_SVH
`define PBC_DEFS_SVH

// register offset on the management register port
`define PBC_CTRL_ADDR 5'h00
// nominal reset value before straps are applied
`define PBC_CTRL_RESET 16'h1000
// bits that software may write; one-way enable and low bits stay zero
`define PBC_WR_MASK 16'hFFC0
// field positions
`define PBC_BIT_SOFT_RESET 15
`define PBC_BIT_LOOPBACK 14
`define PBC_BIT_SPEED_LSB 13
`define PBC_BIT_NEG_EN 12
`define PBC_BIT_POWER_DOWN 11
`define PBC_BIT_ISOLATE 10
`define PBC_BIT_NEG_RESTART 9
`define PBC_BIT_DUPLEX 8
`define PBC_BIT_COL_TEST 7
`define PBC_BIT_SPEED_MSB 6
`define PBC_BIT_ONE_WAY 5
// speed codes {msb, lsb}
`define PBC_SPEED_10 2'b00
`define PBC_SPEED_100 2'b01
// default length of the core reset pulse, in clock cycles
`define PBC_RESET_CYCLES 16

`endif

// [core/pbc_pkg.sv]
// types shared by the basic phy control register core
// assumes pbc_defs.svh is on the include path
package pbc_pkg;

  // control register image, bit 15 first
  typedef struct packed {
    logic soft_reset_trigger;
    logic loopback;
    logic speed_lsb;
    logic negotiation_enable;
    logic soft_power_down;
    logic isolate;
    logic negotiation_restart;
    logic full_half_select;
    logic collision_signal_test;
    logic speed_msb;
    logic one_way_enable;
    logic [4:0] unused;
  } pbc_ctrl_t;

  // management register request, one cycle per access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } pbc_req_t;

  // soft reset sequencer
  typedef enum logic [1:0] {
    PBC_IDLE = 2'b01,
    PBC_RUN = 2'b10
  } pbc_state_t;

endpackage

// [core/pbc_core.sv]
// basic phy control register with its control outputs to the phy core
// assumes requests come from logic on clk; straps and link state are
// asynchronous pins and are synchronised here
//
// Contract
// - soft reset pulses core reset, then self-clears
// - loopback bit drives loopback output, resets zero
// - speed code 01 is 100, 00 is 10
// - reset value loaded from strap pins
// - negotiation enable runs negotiation, defaults one; the core loads it from the negotiation strap
// - power-down bit powers down, strap default
// - strapped power-down keeps device inactive until cleared; tx_allow_r follows link and power_down_r stays low for one cycle after reset
// - isolate bit releases all mac side drivers
// - restart bit pulses restart, then self-clears; the core pulses it only while negotiation enable is set
// - collision test bit enables collision signal test
// - one-way enable reads zero, ignores writes
// - transmit allowed only with valid link
`timescale 1ns/10ps
`include "pbc_defs.svh"

module pbc_core
  import pbc_pkg::*;
#(
  parameter int RST_CYCLES = `PBC_RESET_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire pbc_req_t req,
  output logic [15:0] rd_data_r,
  input wire logic strap_speed_100,
  input wire logic strap_neg_enable,
  input wire logic strap_power_down,
  input wire logic link_valid,
  output logic core_reset_r,
  output logic loopback_r,
  output logic speed_100_r,
  output logic neg_enable_r,
  output logic neg_restart_r,
  output logic power_down_r,
  output logic mac_oe_r,
  output logic full_duplex_r,
  output logic col_test_r,
  output logic tx_allow_r
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------

  // register image after reset, built from the straps
  function automatic pbc_ctrl_t strap_ctrl(input logic spd,
                                           input logic neg,
                                           input logic pd);
    pbc_ctrl_t c;
    c = pbc_ctrl_t'(`PBC_CTRL_RESET);
    c.speed_lsb = spd;
    c.negotiation_enable = neg;
    c.soft_power_down = pd;
    return c;
  endfunction

  // true only for the 100 Mbps code; reserved codes fall back to 10
  function automatic logic is_100(input logic msb, input logic lsb);
    return {msb, lsb} == `PBC_SPEED_100;
  endfunction

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------

  logic [3:0] pin_s1; // first stage, read only by second stage
  logic [3:0] pin_s2; // {link, pd, neg, speed}

  // two flops per pin, no reset so straps settle during reset
  always_ff @(posedge clk) begin
    pin_s1 <= {link_valid, strap_power_down, strap_neg_enable,
               strap_speed_100};
    pin_s2 <= pin_s1;
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------

  pbc_ctrl_t ctrl_r; // the register image
  pbc_state_t st_r; // soft reset sequencer
  logic [15:0] cnt_r; // soft reset length counter
  logic load_r; // first cycle after reset release
  logic wr_hit; // write to the control register
  logic rst_done; // last cycle of the soft reset pulse
  pbc_ctrl_t strapped; // strap defaults

  assign wr_hit = req.wr && (req.addr == `PBC_CTRL_ADDR);
  assign rst_done = (st_r == PBC_RUN) &&
                    (cnt_r == 16'(RST_CYCLES - 1));
  assign strapped = strap_ctrl(pin_s2[0], pin_s2[1], pin_s2[2]);

  // strap load flag, high for one cycle after release
  always_ff @(posedge clk) begin
    if (reset) begin
      load_r <= 1'b1;
    end else begin
      load_r <= 1'b0;
    end
  end

  // soft reset sequencer and counter
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= PBC_IDLE;
      cnt_r <= 16'h0000;
    end else begin
      unique case (st_r)
        PBC_IDLE: begin
          cnt_r <= 16'h0000;
          // start when the trigger bit is seen set
          if (ctrl_r.soft_reset_trigger && !load_r) begin
            st_r <= PBC_RUN;
          end
        end
        PBC_RUN: begin
          cnt_r <= cnt_r + 16'h0001;
          if (rst_done) begin
            st_r <= PBC_IDLE;
          end
        end
      endcase
    end
  end

  // register image: straps, soft reset, writes, self clearing
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_r <= pbc_ctrl_t'(`PBC_CTRL_RESET);
    end else if (load_r) begin
      ctrl_r <= strapped;
    end else if (st_r == PBC_RUN) begin
      // writes ignored while the core is in reset
      if (rst_done) begin
        ctrl_r <= strapped;
      end
    end else if (wr_hit) begin
      // one-way enable and low bits masked off
      ctrl_r <= pbc_ctrl_t'(req.wdata & `PBC_WR_MASK);
    end else if (ctrl_r.negotiation_restart) begin
      ctrl_r.negotiation_restart <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------

  // read data one cycle after the strobe, zero for other addresses
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data_r <= 16'h0000;
    end else if (req.rd) begin
      if (req.addr == `PBC_CTRL_ADDR) begin
        rd_data_r <= ctrl_r;
      end else begin
        rd_data_r <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------

  // mode outputs follow the register one cycle later
  always_ff @(posedge clk) begin
    if (reset) begin
      core_reset_r <= 1'b0;
      loopback_r <= 1'b0;
      speed_100_r <= 1'b0;
      neg_enable_r <= 1'b1;
      neg_restart_r <= 1'b0;
      power_down_r <= 1'b0;
      mac_oe_r <= 1'b0;
      full_duplex_r <= 1'b0;
      col_test_r <= 1'b0;
      tx_allow_r <= 1'b0;
    end else begin
      core_reset_r <= (st_r == PBC_RUN);
      loopback_r <= ctrl_r.loopback;
      speed_100_r <= is_100(ctrl_r.speed_msb, ctrl_r.speed_lsb);
      neg_enable_r <= ctrl_r.negotiation_enable;
      // restart pulse only when negotiation is running
      neg_restart_r <= ctrl_r.negotiation_restart &&
                       ctrl_r.negotiation_enable;
      power_down_r <= ctrl_r.soft_power_down;
      mac_oe_r <= !ctrl_r.isolate;
      // duplex output follows the select bit whether negotiation is on or off
      full_duplex_r <= ctrl_r.full_half_select;
      col_test_r <= ctrl_r.collision_signal_test;
      // no transmit without link, or when down, in reset or isolated
      tx_allow_r <= pin_s2[3] && !ctrl_r.soft_power_down &&
                    !ctrl_r.isolate && (st_r == PBC_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_soft_reset_ends: assert property (
    $rose(core_reset_r) |-> ##[1:70] !ctrl_r.soft_reset_trigger)
    else $error("soft reset bit did not self clear");
  chk_loopback_follow: assert property (
    ##1 loopback_r == $past(ctrl_r.loopback))
    else $error("loopback output wrong");
  chk_speed_decode: assert property (
    ##1 speed_100_r == ($past(ctrl_r.speed_msb) == 1'b0 &&
                        $past(ctrl_r.speed_lsb) == 1'b1))
    else $error("speed decode wrong");
  chk_strap_load: assert property (
    load_r |=> ctrl_r.speed_lsb == $past(pin_s2[0]) &&
               ctrl_r.negotiation_enable == $past(pin_s2[1]) &&
               ctrl_r.soft_power_down == $past(pin_s2[2]))
    else $error("straps not loaded");
  chk_pd_inactive: assert property (
    ctrl_r.soft_power_down |=> power_down_r && !tx_allow_r)
    else $error("device active while powered down");
  chk_isolate_oe: assert property (
    ctrl_r.isolate |=> !mac_oe_r && !tx_allow_r)
    else $error("mac drivers on while isolated");
  chk_restart_clear: assert property (
    ctrl_r.negotiation_restart && st_r == PBC_IDLE && !wr_hit &&
    !load_r |=> !ctrl_r.negotiation_restart)
    else $error("restart bit did not clear");
  chk_one_way_zero: assert property (
    ##1 req.rd |=> rd_data_r[`PBC_BIT_ONE_WAY] == 1'b0)
    else $error("one-way enable read nonzero");
  chk_tx_link: assert property (
    !pin_s2[3] |=> !tx_allow_r)
    else $error("transmit allowed without link");

endmodule

// [dv/pbc_host.sv]
// host model driving the register port of the control register core
// assumes clk is the core clock; requests change at falling edges
`timescale 1ns/10ps

module pbc_host
  import pbc_pkg::*;
(
  input wire logic clk,
  output pbc_req_t req
);
  // ------------------------------------------------------------
  // access task
  // ------------------------------------------------------------
  // idle request at time zero
  initial req = '0;

  // one strobe cycle; released lines go scrambled, not held
  task automatic xfer(input logic w, input logic [4:0] a,
                      input logic [15:0] d);
    @(negedge clk);
    req <= {w, !w, a, d};
    @(negedge clk);
    req <= {1'b0, 1'b0, ~a, ~d};
  endtask
endmodule

// [dv/phy_basic_control_register_tb.sv]
// self-checking bench for the basic phy control register core
// assumes pbc_host drives the register port; straps stay fixed
`timescale 1ns/10ps

module phy_basic_control_register_tb import pbc_pkg::*;;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  logic clk, reset, s100, sneg, spd, link_valid, rd_d;
  pbc_req_t req;
  logic [15:0] rd_data_r, strap_word;
  logic core_reset_r, loopback_r, speed_100_r, neg_enable_r;
  logic neg_restart_r, power_down_r, mac_oe_r, full_duplex_r;
  logic col_test_r, tx_allow_r;
  int failures, cmp_count;
  logic [15:0] exp_q[$]; // expected read words, oldest first

  pbc_host host (.clk(clk), .req(req));
  pbc_core #(.RST_CYCLES(2)) dut (.clk(clk), .reset(reset), .req(req),
    .rd_data_r(rd_data_r), .strap_speed_100(s100),
    .strap_neg_enable(sneg), .strap_power_down(spd),
    .link_valid(link_valid), .core_reset_r(core_reset_r),
    .loopback_r(loopback_r), .speed_100_r(speed_100_r),
    .neg_enable_r(neg_enable_r), .neg_restart_r(neg_restart_r),
    .power_down_r(power_down_r), .mac_oe_r(mac_oe_r),
    .full_duplex_r(full_duplex_r), .col_test_r(col_test_r),
    .tx_allow_r(tx_allow_r));

  // ------------------------------------------------------------
  // clock, compare, finish
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // read data lands one edge after the taking edge
  always @(posedge clk) rd_d <= req.rd;
  always @(negedge clk) if (rd_d === 1'b1) chk(rd_data_r, exp_q.pop_front());

  // bus helpers; write leaves one cycle for mode outputs to follow
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    host.xfer(1'b1, a, d);
    @(negedge clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, a, 16'h0000);
  endtask

  // hang guard
  initial begin
    #20000;
    failures++;
    complete_run();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    failures = 0;
    cmp_count = 0;
    reset = 1'b1;
    link_valid = 1'b1;
    {s100, sneg, spd} = 3'($urandom(42997));
    strap_word = {2'b00, s100, sneg, spd, 11'h000};
    repeat (4) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    rd(5'h00, strap_word);
    chk(neg_enable_r, sneg);
    chk(speed_100_r, s100);
    chk(power_down_r, spd);
    chk(tx_allow_r, !spd);
    wr(5'h00, 16'h0000);
    chk(tx_allow_r, 16'h0001);
    link_valid = 1'b0;
    repeat (4) @(negedge clk);
    chk(tx_allow_r, 16'h0000);
    link_valid = 1'b1;
    // loopback, isolate, duplex, collision test together
    wr(5'h00, 16'h4580);
    rd(5'h00, 16'h4580);
    chk({loopback_r, mac_oe_r, full_duplex_r}, 16'h0005);
    chk({col_test_r, tx_allow_r}, 16'h0002);
    // every speed code, manual mode
    for (int c = 0; c < 4; c++) begin
      wr(5'h00, {2'b00, c[0], 6'h00, c[1], 6'h00});
      chk(speed_100_r, c == 1);
    end
    chk({loopback_r, mac_oe_r, neg_enable_r}, 16'h0002);
    wr(5'h00, 16'h013F);
    rd(5'h00, 16'h0100);
    // software power-down, whatever the strap said
    wr(5'h00, 16'h0800);
    chk({power_down_r, tx_allow_r}, 16'h0002);
    // restart pulse and self clear
    wr(5'h00, 16'h1200);
    repeat (10) if (neg_restart_r !== 1'b1) @(negedge clk);
    chk(neg_restart_r, 16'h0001);
    rd(5'h00, 16'h1000);
    // unmapped address leaves the register alone
    wr(5'h03, 16'h4000);
    rd(5'h03, 16'h0000);
    rd(5'h00, 16'h1000);
    // soft reset runs, ends, reloads straps
    wr(5'h00, 16'h8000);
    repeat (10) if (core_reset_r !== 1'b1) @(negedge clk);
    chk(core_reset_r, 16'h0001);
    repeat (20) if (core_reset_r !== 1'b0) @(negedge clk);
    chk(core_reset_r, 16'h0000);
    rd(5'h00, strap_word);
    repeat (2) @(negedge clk);
    complete_run();
  end
endmodule
